// ===== tb/tb_tmpwm_top.sv
// Testbench: APB register tasks and pulse measurements through the model.
// Assumes zero-wait APB slave and f1 equal to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module tb_tmpwm_top;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, err, trig, slow, pulse, irq;
	logic [2:0] ovf;
	int n_rise, n_fall, n_irq, hi_w, per_w, i, s0;
	int error_cnt = 0;
	int n_checks = 0;
	logic [1:0] cs [6] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h3};
	logic [3:0] pz [6] = '{4'h0, 4'h0, 4'h0, 4'h3, 4'h5, 4'h0};
	int tk [6] = '{8, 1, 1, 6, 10, 6};
	always #5 ref_clk = ~ref_clk;
	tmpwm_top tmpwm_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trigger_in_pin(trig), .other_ovf(ovf),
		.slow_clk_32(slow), .pulse_out_pin(pulse), .irq_req(irq));
	tmpwm_partner tmpwm_partner_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.pulse_out_pin(pulse), .irq_req(irq), .trigger_in_pin(trig), .other_ovf(ovf),
		.slow_clk_32(slow), .n_rise(n_rise), .n_fall(n_fall), .n_irq(n_irq),
		.hi_w(hi_w), .per_w(per_w));
	////////////////////////////////////////
	task summarize;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			chk("pready", 32'h1, 32'h0);
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask : rdc
	task wait_rise(input int n, input int lim);
		int s;
		s = n_rise;
		for (int j = 0; j < lim; j++) begin
			@(posedge ref_clk);
			#1;
			if (n_rise >= s + n) return;
		end
		chk("pulse rise", 32'h1, 32'h0);
		summarize();
	endtask : wait_rise
	// Stop only while low, so every fall is a counted fall
	task wait_low(input int lim);
		for (int j = 0; j < lim; j++) begin
			@(posedge ref_clk);
			#1;
			if (pulse !== 1'b1) return;
		end
		chk("pulse fall", 32'h1, 32'h0);
		summarize();
	endtask : wait_low
	function automatic logic [31:0] md(input logic [1:0] op, input logic e, input logic t,
		input logic w, input logic [1:0] c);
		md = 32'h0;
		md[tmpwm_pkg::MODE_OP_LSB +: 2] = op;
		md[tmpwm_pkg::MODE_EDGE_BIT] = e;
		md[tmpwm_pkg::MODE_TSRC_BIT] = t;
		md[tmpwm_pkg::MODE_WIDTH_BIT] = w;
		md[tmpwm_pkg::MODE_CLK_LSB +: 2] = c;
	endfunction : md
	////////////////////////////////////////
	initial begin
		paddr <= 8'h00;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		pwdata <= 32'h0;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdc("mode", tmpwm_pkg::OFF_MODE, '1, {24'h0, tmpwm_pkg::MODE_RST});
		rdc("presc", tmpwm_pkg::OFF_PRESC, '1, {28'h0, tmpwm_pkg::PRESC_RST});
		rdc("count", tmpwm_pkg::OFF_COUNT, '1, {16'h0, tmpwm_pkg::COUNT_RST});
		apb(1'b1, 8'h40, '1);
		chk("wr unmapped", 32'h1, {31'h0, err});
		rdc("unmapped", 8'h40, '1, 32'h0);
		chk("rd unmapped", 32'h1, {31'h0, err});
		wr(tmpwm_pkg::OFF_MODE, 32'hff);
		rdc("mode b2", tmpwm_pkg::OFF_MODE, '1, {24'h0, tmpwm_pkg::MODE_WMASK});
		// 16-bit, rising pin edge, stop in the last high cycle of a pulse
		tmpwm_partner_i.pin_to(1'b1);
		wr(tmpwm_pkg::OFF_MODE, md(tmpwm_pkg::OP_PWM, 1'b1, 1'b1, 1'b0, 2'h0));
		wr(tmpwm_pkg::OFF_TRIG, {30'h0, tmpwm_pkg::TSRC_PIN});
		wr(tmpwm_pkg::OFF_COUNT, 32'h5);
		wr(tmpwm_pkg::OFF_RUN, 32'h1);
		tmpwm_partner_i.pin_to(1'b0);
		rdc("fall ignored", tmpwm_pkg::OFF_STATUS, 32'h1, 32'h0);
		tmpwm_partner_i.pin_to(1'b1);
		wait_rise(1, 20);
		tmpwm_partner_i.pin_to(1'b0);
		tmpwm_partner_i.pin_to(1'b1);
		wait_rise(1, 70000);
		chk("high16", 32'd5, hi_w);
		chk("period16", 32'd65535, per_w);
		wr(tmpwm_pkg::OFF_RUN, 32'h0);
		rdc("stopped", tmpwm_pkg::OFF_STATUS, 32'h3, 32'h0);
		s0 = n_rise;
		repeat (300) @(posedge ref_clk);
		chk("idle rises", s0, n_rise);
		// 8-bit m=1 n=3, reload written while counting
		wr(tmpwm_pkg::OFF_COUNT, 32'h0301);
		wr(tmpwm_pkg::OFF_MODE, md(tmpwm_pkg::OP_PWM, 1'b0, 1'b0, 1'b1, 2'h0));
		wr(tmpwm_pkg::OFF_RUN, 32'h1);
		wait_rise(3, 3000);
		chk("high8", 32'd6, hi_w);
		chk("period8", 32'd510, per_w);
		wr(tmpwm_pkg::OFF_COUNT, 32'h0201);
		wait_rise(1, 600);
		chk("high8 old", 32'd6, hi_w);
		wait_rise(1, 600);
		chk("high8 new", 32'd4, hi_w);
		wr(tmpwm_pkg::OFF_RUN, 32'h0);
		// Overflow routes with edge bit ignored
		wr(tmpwm_pkg::OFF_COUNT, 32'h2);
		wr(tmpwm_pkg::OFF_MODE, md(tmpwm_pkg::OP_PWM, 1'b0, 1'b1, 1'b0, 2'h0));
		for (int k = 1; k < 4; k++) begin
			wr(tmpwm_pkg::OFF_TRIG, 32'(k));
			wr(tmpwm_pkg::OFF_RUN, 32'h1);
			tmpwm_partner_i.pin_to(1'b0);
			tmpwm_partner_i.pin_to(1'b1);
			rdc("pin ignored", tmpwm_pkg::OFF_STATUS, 32'h1, 32'h0);
			tmpwm_partner_i.ovf(k - 1);
			wait_rise(1, 20);
			wr(tmpwm_pkg::OFF_RUN, 32'h0);
		end
		// Count sources, 8-bit m=0 n=1
		wr(tmpwm_pkg::OFF_COUNT, 32'h0100);
		for (int k = 0; k < 6; k++) begin
			wr(tmpwm_pkg::OFF_PRESC, {28'h0, pz[k]});
			wr(tmpwm_pkg::OFF_MODE, md(tmpwm_pkg::OP_PWM, 1'b0, 1'b0, 1'b1, cs[k]));
			wr(tmpwm_pkg::OFF_RUN, 32'h1);
			wait_rise(3, 10000);
			chk("tick high", tk[k], hi_w);
			chk("tick period", 255 * tk[k], per_w);
			wait_low(40);
			wr(tmpwm_pkg::OFF_RUN, 32'h0);
		end
		// One-shot started by the software bit
		wr(tmpwm_pkg::OFF_COUNT, 32'h4);
		wr(tmpwm_pkg::OFF_MODE, md(tmpwm_pkg::OP_ONESHOT, 1'b0, 1'b0, 1'b0, 2'h0));
		wr(tmpwm_pkg::OFF_TRIG, 32'h0);
		wr(tmpwm_pkg::OFF_RUN, 32'h1);
		rdc("oneshot idle", tmpwm_pkg::OFF_STATUS, 32'h1, 32'h0);
		wr(tmpwm_pkg::OFF_TRIG, 32'h4);
		wait_rise(1, 20);
		repeat (20) @(posedge ref_clk);
		rdc("oneshot done", tmpwm_pkg::OFF_STATUS, 32'h3, 32'h0);
		chk("irq", n_fall, n_irq);
		summarize();
	end
endmodule : tb_tmpwm_top
`default_nettype wire

// ===== tb/tmpwm_partner.sv
// Far side: trigger pin, overflow pulses, slow clock, pulse load meter.
// Assumes one ref_clk domain; widths are counted in ref_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module tmpwm_partner (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic pulse_out_pin,
	input wire logic irq_req,
	output var logic trigger_in_pin,
	output var logic [2:0] other_ovf,
	output var logic slow_clk_32,
	output var int n_rise,
	output var int n_fall,
	output var int n_irq,
	output var int hi_w,
	output var int per_w
);
	int hi;
	int per;
	int sc;
	logic prev;
	initial begin
		trigger_in_pin = 1'b0;
		other_ovf = 3'h0;
		slow_clk_32 = 1'b0;
		sc = 0;
	end
	////////////////////////////////////////
	// Slow source: a rising edge every 6 cycles
	always @(posedge ref_clk) begin
		sc = (sc + 1) % 3;
		if (sc == 0) slow_clk_32 <= ~slow_clk_32;
	end
	////////////////////////////////////////
	// Load: high width, rise-to-rise period, request count
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			n_rise = 0;
			n_fall = 0;
			n_irq = 0;
			hi = 0;
			per = 0;
			prev = 1'b0;
		end else begin
			per = per + 1;
			if (pulse_out_pin === 1'b1) hi = hi + 1;
			if (pulse_out_pin === 1'b1 && prev !== 1'b1) begin
				n_rise = n_rise + 1;
				per_w = per;
				per = 0;
			end
			if (pulse_out_pin !== 1'b1 && prev === 1'b1) begin
				n_fall = n_fall + 1;
				hi_w = hi;
				hi = 0;
			end
			if (irq_req === 1'b1) n_irq = n_irq + 1;
			prev = pulse_out_pin;
		end
	end
	////////////////////////////////////////
	// Trigger pin level, changed just after an edge
	task pin_to(input logic v);
		@(posedge ref_clk);
		trigger_in_pin <= v;
	endtask : pin_to
	// One-cycle overflow pulse of another timer
	task ovf(input int k);
		@(posedge ref_clk);
		other_ovf[k] <= 1'b1;
		@(posedge ref_clk);
		other_ovf[k] <= 1'b0;
	endtask : ovf
endmodule : tmpwm_partner
`default_nettype wire

// ===== verilog/tmpwm_pkg.sv
// Package for the timer channel: register map, field positions, modes, states.
// Assumes a 32-bit APB slave with one aligned word per register.
package tmpwm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_RUN = 8'h04;
	localparam logic [7:0] OFF_TRIG = 8'h08;
	localparam logic [7:0] OFF_PRESC = 8'h0c;
	localparam logic [7:0] OFF_COUNT = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;

	// Mode register fields
	localparam int MODE_OP_LSB = 0;
	localparam int MODE_EDGE_BIT = 3;
	localparam int MODE_TSRC_BIT = 4;
	localparam int MODE_WIDTH_BIT = 5;
	localparam int MODE_CLK_LSB = 6;
	localparam logic [7:0] MODE_WMASK = 8'hfb;

	// Run, trigger route and prescale fields
	localparam int RUN_BIT = 0;
	localparam int TRIG_SRC_LSB = 0;
	localparam int TRIG_SOFT_BIT = 2;
	localparam int PRESC_LSB = 0;

	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [1:0] TSRC_RST = 2'h0;
	localparam logic [3:0] PRESC_RST = 4'h0;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	// Operation modes
	localparam logic [1:0] OP_ONESHOT = 2'h2;
	localparam logic [1:0] OP_PWM = 2'h3;

	// Trigger sources
	localparam logic [1:0] TSRC_PIN = 2'h0;

	// Count source selections
	localparam logic [1:0] CLK_F1 = 2'h0;
	localparam logic [1:0] CLK_F8 = 2'h1;
	localparam logic [1:0] CLK_F2N = 2'h2;
	localparam logic [1:0] CLK_SLOW = 2'h3;
	localparam logic [2:0] F8_LAST = 3'h7;

	// Last period step: period is last value plus one
	localparam logic [15:0] PER16_LAST = 16'hfffe;
	localparam logic [15:0] PER8_LAST = 16'h00fe;

	typedef enum logic [1:0] {
		TMPWM_IDLE = 2'b01,
		TMPWM_RUN = 2'b10
	} tmpwm_state_t;

endpackage : tmpwm_pkg

// ===== verilog/tmpwm_tick.sv
// Count source generator: one-cycle tick per count source edge.
// Assumes slow_clk_32 is a level synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module tmpwm_tick (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic slow_clk_32,
	tmpwm_tick_if.gen tk
);
	logic [2:0] f8_q, f8_d;
	logic [4:0] f2n_q, f2n_d;
	logic slow_prev_q, slow_prev_d;
	logic tick_q, tick_d;
	logic [4:0] f2n_last;

	always_comb begin
		f2n_last = {tk.prescale, 1'b0} - 5'd1;
		f8_d = f8_q + 3'd1;
		slow_prev_d = slow_clk_32;
		f2n_d = f2n_q + 5'd1;
		if (f2n_q >= f2n_last) begin
			f2n_d = 5'd0;
		end
		case (tk.clk_sel)
			tmpwm_pkg::CLK_F1: tick_d = 1'b1;
			tmpwm_pkg::CLK_F8: tick_d = (f8_q == tmpwm_pkg::F8_LAST);
			tmpwm_pkg::CLK_F2N: begin
				// Zero means undivided, else divide by twice the field
				tick_d = (tk.prescale == 4'h0) || (f2n_q >= f2n_last);
			end
			tmpwm_pkg::CLK_SLOW: tick_d = slow_clk_32 && !slow_prev_q;
			default: tick_d = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			f8_q <= 3'd0;
			f2n_q <= 5'd0;
			slow_prev_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			f8_q <= f8_d;
			f2n_q <= f2n_d;
			slow_prev_q <= slow_prev_d;
			tick_q <= tick_d;
		end
	end

	assign tk.tick = tick_q;

	a_f2n_spacing: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(tk.clk_sel == tmpwm_pkg::CLK_F2N && tk.prescale != 4'h0 && $stable(tk.prescale)
		&& $stable(tk.clk_sel) && tick_q) |=> !tick_q)
		else $error("prescaled tick came on consecutive cycles");

endmodule : tmpwm_tick
`default_nettype wire

// ===== verilog/tmpwm_tick_if.sv
// Interface between the timer core and its count source generator.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface tmpwm_tick_if;
	logic [1:0] clk_sel;
	logic [3:0] prescale;
	logic tick;
	modport core (output clk_sel, output prescale, input tick);
	modport gen (input clk_sel, input prescale, output tick);
endinterface : tmpwm_tick_if
`default_nettype wire

// ===== verilog/tmpwm_top.sv
// Timer channel with one-shot and 16/8-bit PWM modes behind an APB slave.
// Assumes APB on ref_clk; trigger pin and overflow inputs synchronous.
//
// Operation
// - Mode bits 10 select one-shot
// - Edge bit: 0 falling, 1 rising pin edge
// - Trigger select: soft start or routed source (PWM with no routed source starts on the run bit alone)
// - Prescale zero undivided, else divide 2n
// - Edge bit ignored for overflow sources
// - PWM reloads at each output rising edge
// - Triggers ignored while PWM counts
// - 16-bit high time equals n cycles
// - 16-bit period fixed 65535 cycles
// - 8-bit: prescale m+1, high n, period 255
// - Start needs run bit and a trigger
// - Clearing run bit stops PWM
// - Interrupt request on output falling edge
// - Pin roles: trigger input, pulse output
// - Counter read value is undefined
// - Write when stopped loads reload and counter
// - Write while counting loads reload only
// - Mode bits 11 select PWM
// - Width bit: 0 is 16-bit, 1 is 8-bit
`timescale 1ns/1ps
`default_nettype none
module tmpwm_top (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic trigger_in_pin,
	input wire logic [2:0] other_ovf,
	input wire logic slow_clk_32,
	output logic pulse_out_pin,
	output logic irq_req
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// High-time value: full word in 16-bit form, upper byte in 8-bit form
	function automatic logic [15:0] hi_value(input logic width8, input logic [15:0] val);
		hi_value = width8 ? {8'h00, val[15:8]} : val;
	endfunction : hi_value

	function automatic logic reg_hit(input logic [7:0] addr);
		reg_hit = (addr == tmpwm_pkg::OFF_MODE) || (addr == tmpwm_pkg::OFF_RUN)
			|| (addr == tmpwm_pkg::OFF_TRIG) || (addr == tmpwm_pkg::OFF_PRESC)
			|| (addr == tmpwm_pkg::OFF_COUNT) || (addr == tmpwm_pkg::OFF_STATUS);
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////////
	// Registers and count source

	logic [7:0] mode_q, mode_d;
	logic run_q, run_d;
	logic [1:0] tsrc_q, tsrc_d;
	logic [3:0] presc_q, presc_d;
	logic [15:0] reload_q, reload_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pslverr_q, pslverr_d;
	logic soft_q, soft_d;
	logic pin_prev_q;

	tmpwm_pkg::tmpwm_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] per_q, per_d;
	logic [7:0] pre_q, pre_d;
	logic out_q, out_d;
	logic irq_q, irq_d;
	logic first_q, first_d;

	tmpwm_tick_if tk ();
	assign tk.clk_sel = mode_q[tmpwm_pkg::MODE_CLK_LSB +: 2];
	assign tk.prescale = presc_q;

	tmpwm_tick u_tick (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.slow_clk_32(slow_clk_32),
		.tk(tk)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB register file

	logic wr_en;
	logic wr_count;
	logic [1:0] op_mode;
	logic width8;
	logic is_pwm;
	logic is_oneshot;

	always_comb begin
		wr_en = psel && penable && pwrite && pready_q;
		wr_count = wr_en && (paddr == tmpwm_pkg::OFF_COUNT);
		op_mode = mode_q[tmpwm_pkg::MODE_OP_LSB +: 2];
		is_pwm = (op_mode == tmpwm_pkg::OP_PWM);
		is_oneshot = (op_mode == tmpwm_pkg::OP_ONESHOT);
		width8 = mode_q[tmpwm_pkg::MODE_WIDTH_BIT];
		mode_d = mode_q;
		run_d = run_q;
		tsrc_d = tsrc_q;
		presc_d = presc_q;
		soft_d = 1'b0;
		if (wr_en) begin
			case (paddr)
				tmpwm_pkg::OFF_MODE: mode_d = pwdata[7:0] & tmpwm_pkg::MODE_WMASK;
				tmpwm_pkg::OFF_RUN: run_d = pwdata[tmpwm_pkg::RUN_BIT];
				tmpwm_pkg::OFF_TRIG: begin
					tsrc_d = pwdata[tmpwm_pkg::TRIG_SRC_LSB +: 2];
					soft_d = pwdata[tmpwm_pkg::TRIG_SOFT_BIT];
				end
				tmpwm_pkg::OFF_PRESC: presc_d = pwdata[tmpwm_pkg::PRESC_LSB +: 4];
				default: ;
			endcase
		end
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		if (psel && !penable) begin
			pslverr_d = !reg_hit(paddr);
			case (paddr)
				tmpwm_pkg::OFF_MODE: prdata_d = {24'h000000, mode_q};
				tmpwm_pkg::OFF_RUN: prdata_d = {31'h00000000, run_q};
				tmpwm_pkg::OFF_TRIG: prdata_d = {30'h00000000, tsrc_q};
				tmpwm_pkg::OFF_PRESC: prdata_d = {28'h0000000, presc_q};
				// Live count, not a reliable value in PWM
				tmpwm_pkg::OFF_COUNT: prdata_d = {16'h0000, cnt_q};
				tmpwm_pkg::OFF_STATUS: begin
					prdata_d = {30'h00000000, out_q, state_q == tmpwm_pkg::TMPWM_RUN};
				end
				default: prdata_d = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger selection

	logic pin_edge;
	logic src_trig;
	logic trig;
	logic start;

	always_comb begin
		pin_edge = mode_q[tmpwm_pkg::MODE_EDGE_BIT] ? (trigger_in_pin && !pin_prev_q)
			: (!trigger_in_pin && pin_prev_q);
		// Edge choice only matters for the pin source
		if (tsrc_q == tmpwm_pkg::TSRC_PIN) begin
			src_trig = pin_edge;
		end else begin
			src_trig = other_ovf[tsrc_q - 2'd1];
		end
		if (mode_q[tmpwm_pkg::MODE_TSRC_BIT]) begin
			trig = src_trig;
		end else if (is_oneshot) begin
			trig = soft_q;
		end else begin
			trig = 1'b1;
		end
		start = run_q && trig;
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter core

	logic step;
	logic [15:0] per_last;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		per_d = per_q;
		pre_d = pre_q;
		out_d = out_q;
		irq_d = 1'b0;
		first_d = first_q;
		reload_d = reload_q;
		per_last = width8 ? tmpwm_pkg::PER8_LAST : tmpwm_pkg::PER16_LAST;
		step = 1'b0;
		if (tk.tick) begin
			if (!width8 || !is_pwm) begin
				step = 1'b1;
			end else if (pre_q == 8'h00) begin
				pre_d = reload_q[7:0];
				step = 1'b1;
			end else begin
				pre_d = pre_q - 8'h01;
			end
		end
		case (state_q)
			tmpwm_pkg::TMPWM_IDLE: begin
				out_d = 1'b0;
				if (start && is_pwm) begin
					state_d = tmpwm_pkg::TMPWM_RUN;
					cnt_d = hi_value(width8, reload_q);
					per_d = per_last;
					pre_d = reload_q[7:0];
					out_d = (hi_value(width8, reload_q) != 16'h0000);
					first_d = 1'b0;
				end else if (start && is_oneshot && reload_q != 16'h0000) begin
					state_d = tmpwm_pkg::TMPWM_RUN;
					cnt_d = reload_q;
					out_d = 1'b1;
					first_d = 1'b0;
				end
			end
			tmpwm_pkg::TMPWM_RUN: begin
				if (tk.tick) begin
					first_d = 1'b1;
				end
				if (is_oneshot && start) begin
					cnt_d = reload_q;
				end else if (is_oneshot && step) begin
					if (cnt_q == 16'h0001) begin
						cnt_d = reload_q;
						irq_d = 1'b1;
						out_d = 1'b0;
						state_d = tmpwm_pkg::TMPWM_IDLE;
					end else begin
						cnt_d = cnt_q - 16'h0001;
					end
				end else if (is_pwm && step) begin
					// Further triggers have no effect here
					if (per_q == 16'h0000) begin
						per_d = per_last;
						cnt_d = hi_value(width8, reload_q);
						out_d = (hi_value(width8, reload_q) != 16'h0000);
					end else begin
						per_d = per_q - 16'h0001;
						if (cnt_q != 16'h0000) begin
							cnt_d = cnt_q - 16'h0001;
							if (cnt_q == 16'h0001) begin
								out_d = 1'b0;
								irq_d = 1'b1;
							end
						end
					end
				end
				if (!run_q || !(is_pwm || is_oneshot)) begin
					state_d = tmpwm_pkg::TMPWM_IDLE;
					out_d = 1'b0;
				end
			end
			default: begin
				state_d = tmpwm_pkg::TMPWM_IDLE;
				out_d = 1'b0;
			end
		endcase
		if (wr_count) begin
			reload_d = pwdata[15:0];
			if (state_q == tmpwm_pkg::TMPWM_IDLE || !first_q) begin
				cnt_d = is_pwm ? hi_value(width8, pwdata[15:0]) : pwdata[15:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= tmpwm_pkg::MODE_RST;
			run_q <= 1'b0;
			tsrc_q <= tmpwm_pkg::TSRC_RST;
			presc_q <= tmpwm_pkg::PRESC_RST;
			reload_q <= tmpwm_pkg::COUNT_RST;
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			soft_q <= 1'b0;
			pin_prev_q <= 1'b0;
			state_q <= tmpwm_pkg::TMPWM_IDLE;
			cnt_q <= tmpwm_pkg::COUNT_RST;
			per_q <= 16'h0000;
			pre_q <= 8'h00;
			out_q <= 1'b0;
			irq_q <= 1'b0;
			first_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			run_q <= run_d;
			tsrc_q <= tsrc_d;
			presc_q <= presc_d;
			reload_q <= reload_d;
			prdata_q <= prdata_d;
			pready_q <= 1'b1;
			pslverr_q <= pslverr_d;
			soft_q <= soft_d;
			pin_prev_q <= trigger_in_pin;
			state_q <= state_d;
			cnt_q <= cnt_d;
			per_q <= per_d;
			pre_q <= pre_d;
			out_q <= out_d;
			irq_q <= irq_d;
			first_q <= first_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pulse_out_pin = out_q;
	assign irq_req = irq_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_pwm_running;
		state_q == tmpwm_pkg::TMPWM_RUN && is_pwm;
	endsequence

	sequence s_stopped_low;
		state_q == tmpwm_pkg::TMPWM_IDLE ##0 !out_q;
	endsequence

	a_stop_output_low: assert property (!run_q |=> s_stopped_low)
		else $error("output not low after run bit cleared");

	a_idle_out_low: assert property (state_q == tmpwm_pkg::TMPWM_IDLE && $past(state_q)
		== tmpwm_pkg::TMPWM_IDLE |-> !out_q)
		else $error("output high while stopped");

	a_irq_on_fall: assert property (irq_q && is_pwm |-> $fell(out_q))
		else $error("pwm interrupt without falling output");

	a_rise_reload: assert property (s_pwm_running and $rose(out_q) |-> per_q == per_last
		&& cnt_q == hi_value(width8, reload_q))
		else $error("pwm output rose without reload");

	a_no_retrigger: assert property (s_pwm_running and (trig && !tk.tick && run_q && !wr_count
		&& !wr_en) |=> per_q == $past(per_q) && cnt_q == $past(cnt_q))
		else $error("trigger disturbed running pwm");

	a_run_mode_only: assert property (state_q == tmpwm_pkg::TMPWM_RUN |-> op_mode[1])
		else $error("counting in an unsupported mode");

	a_write_stopped: assert property (wr_count && state_q == tmpwm_pkg::TMPWM_IDLE
		&& !start |=> reload_q == $past(pwdata[15:0]) && cnt_q == (is_pwm
		? hi_value(width8, reload_q) : reload_q))
		else $error("write while stopped did not load counter");

	a_write_running: assert property (s_pwm_running and (wr_count && first_q && !step
		&& run_q) |=> reload_q == $past(pwdata[15:0]) && cnt_q == $past(cnt_q))
		else $error("write while counting disturbed counter");

	a_start_needs_run: assert property ($rose(state_q == tmpwm_pkg::TMPWM_RUN)
		|-> $past(run_q))
		else $error("counting started without run bit");

endmodule : tmpwm_top
`default_nettype wire
